// ---- rtl/sdh_ctrl.sv ----
// Card host controller core: AHB-Lite register slave, card clock
// divider, command issue, block transfer engine, card interrupt sense.
// Assumes CMD_I and DAT_I come from pads (synchronised here) and that
// FIFO_STALL comes from the data FIFO on CLK_SYS.
//
// Summary of operation
// R01: Last descriptor must move over 4 bytes
// R02: ADMA1 may append a trailing no-op descriptor
// R03: ADMA read, odd block size, stalls forever
// R04: Software pads block size to multiple of 4
// R05: Poll data line 0 level for busy end
// R06: Block count of one always stops transfer
// R07: Use block counting with count 65535 instead
// R08: Response start during FIFO pause raises errors
// R09: Software retries command after both errors
// R10: Card interrupt sensed only on line edge
// R11: Card interrupt flag cleared by writing one
// R12: Detect bit clear forces inverted line low
// R13: Software follows ordered card interrupt service
// R14: Stop card clock before reset or divider change
// R15: Software reset abandons command and data
// R16: Host sources card clock and drives transfers
// R17: Wait clock stable before enabling card clock
// R18: Clock disabled: card clock static, no traffic
`timescale 1ns/100ps
`include "sdh_regs.svh"

module sdh_ctrl #(
    parameter int STB_CYCLES = `SDH_STB_CYC
) (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST,
    input  wire logic                 CE,
    input  wire logic                 HSEL,
    input  wire logic [31:0]          HADDR,
    input  wire logic [1:0]           HTRANS,
    input  wire logic                 HWRITE,
    input  wire logic [2:0]           HSIZE,
    input  wire logic [31:0]          HWDATA,
    input  wire logic                 HREADY,
    output logic [31:0]               HRDATA,
    output logic                      HREADYOUT,
    output logic                      HRESP,
    input  wire logic                 CMD_I,
    input  wire logic [3:0]           DAT_I,
    input  wire logic                 FIFO_STALL,
    output sdh_pkg::sdh_card_o_t      CARD_O,
    output logic                      IRQ
);
    import sdh_pkg::*;

    if (STB_CYCLES < 1 || STB_CYCLES > 255) begin : g_chk
        $error("STB_CYCLES must lie in 1..255");
    end

    localparam logic [7:0] STB_N = 8'(STB_CYCLES);

    sdh_state_t s;
    sdh_state_t n;
    logic        wr;
    logic        reset_all_bit;
    logic        tick;
    logic        inv;
    logic        card_interrupt_flag_rise;
    logic        blk_end;
    logic        last;
    logic        odd_stall;
    logic [31:0] set;
    logic [31:0] present;

    // Single-word writes only; narrower sizes are taken as full words
    assign wr   = s.a_wr;
    assign reset_all_bit = wr && s.a_addr == `SDH_A_SYSCTL && HWDATA[`SDH_SC_RESET_ALL_BIT];
    assign inv  = s.dat3_card_detect_ctrl & ~s.dat_s2[1]; // R12
    assign card_interrupt_flag_rise = inv & ~s.inv_prev; // R10
    assign blk_end   = s.xst == X_RUN && tick && !FIFO_STALL
                       && s.byte_left <= 12'h001;
    assign last      = s.blk_left == 16'h0001 // R06
                       || (s.xmode[`SDH_XM_BLOCK_COUNT_ENABLE] && s.blk_left == 16'h0000);
    assign odd_stall = s.xmode[`SDH_XM_DMA] && s.xmode[`SDH_XM_RD]
                       && s.block_attributes_reg[1:0] != 2'h0;
    assign present = {4'h0, s.dat_s2, 20'h0_0000,
                      s.stb_cnt == STB_N, s.xst != X_IDLE, 2'h0};

    always_comb begin
        n    = s;
        tick = 1'b0;
        set  = 32'h0000_0000;

        // Pad inputs: first stage feeds only the second
        n.cmd_s1 = CMD_I;
        n.cmd_s2 = s.cmd_s1;
        n.dat_s1 = DAT_I;
        n.dat_s2 = s.dat_s1;

        // Register writes land in the data phase
        if (wr) begin
            unique case (s.a_addr)
                `SDH_A_BLOCK_ATTRIBUTES_REG: n.block_attributes_reg = HWDATA;
                `SDH_A_XMODE:   n.xmode   = HWDATA[4:0];
                `SDH_A_PROTO:   n.dat3_card_detect_ctrl    = HWDATA[`SDH_PC_DAT3_CARD_DETECT_CTRL];
                `SDH_A_SYSCTL: begin
                    n.clken = HWDATA[`SDH_SC_CLKEN];
                    n.div   = HWDATA[`SDH_SC_DIV +: 8];
                    if (n.div != s.div) begin
                        n.stb_cnt = 8'h00;
                    end
                end
                `SDH_A_ISTEN:   n.sten = HWDATA & `SDH_IS_MASK;
                `SDH_A_ISGEN:   n.sgen = HWDATA & `SDH_IS_MASK;
                default: ;
            endcase
        end

        // Card clock: divider restarts the stable count when changed
        if (s.stb_cnt != STB_N) begin
            n.stb_cnt = n.stb_cnt + 8'h01;
        end
        if (!n.clken) begin
            n.sdclk   = 1'b0; // R18
            n.div_cnt = 8'h00;
        end else if (s.div_cnt >= s.div) begin
            n.div_cnt = 8'h00;
            n.sdclk   = ~s.sdclk; // R16
            tick      = ~s.sdclk;
        end else begin
            n.div_cnt = s.div_cnt + 8'h01;
        end

        // Command issue; refused while the card clock is off
        unique case (s.cst)
            C_IDLE: begin
                if (wr && s.a_addr == `SDH_A_XMODE
                    && HWDATA[`SDH_XM_CSTART] && s.clken) begin
                    n.cst = C_SEND;
                end
            end
            C_SEND: if (tick) n.cst = C_WAIT;
            C_WAIT: begin
                if (tick && !s.cmd_s2) begin
                    n.cst = C_IDLE;
                    if (s.xst == X_RUN && FIFO_STALL) begin
                        set[`SDH_IS_CCE] = 1'b1; // R08
                        set[`SDH_IS_CIE] = 1'b1; // R08
                    end else begin
                        set[`SDH_IS_CC] = 1'b1;
                    end
                end
            end
            default: n.cst = C_IDLE;
        endcase

        // Block transfer engine; FIFO pause holds the byte count
        unique case (s.xst)
            X_IDLE: begin
                if (wr && s.a_addr == `SDH_A_XMODE
                    && HWDATA[`SDH_XM_XSTART] && s.clken) begin
                    n.xst       = X_RUN;
                    n.blk_left  = s.block_attributes_reg[`SDH_BA_CNT +: 16];
                    n.byte_left = s.block_attributes_reg[`SDH_BA_BSZ +: 12];
                end
            end
            X_RUN: begin
                if (blk_end) begin
                    n.byte_left = s.block_attributes_reg[`SDH_BA_BSZ +: 12];
                    if (s.xmode[`SDH_XM_BLOCK_COUNT_ENABLE]) begin
                        n.blk_left = s.blk_left - 16'h0001;
                    end
                    if (last && odd_stall) begin
                        n.xst = X_STALL; // R03
                    end else if (last) begin
                        n.xst = X_IDLE;
                        set[`SDH_IS_TC] = 1'b1;
                    end
                end else if (tick && !FIFO_STALL) begin
                    n.byte_left = s.byte_left - 12'h001;
                end
            end
            X_STALL: ; // Only a reset frees the engine
            default: n.xst = X_IDLE;
        endcase

        // Card interrupt: edge of the inverted line only
        n.inv_prev = inv;
        set[`SDH_IS_CARD_INTERRUPT_FLAG] = card_interrupt_flag_rise; // R10

        // Sticky status; a new event wins over a clear
        n.ists = s.ists;
        if (wr && s.a_addr == `SDH_A_ISTAT) begin
            n.ists = s.ists & ~HWDATA; // R11
        end
        n.ists = n.ists | (set & s.sten);

        // Software reset: everything but the bus pipe, the pad synchronisers and inv_prev
        if (reset_all_bit) begin
            n.block_attributes_reg   = 32'h0000_0000;
            n.xmode     = 5'h00;
            n.dat3_card_detect_ctrl      = 1'b0;
            n.clken     = 1'b0;
            n.div       = `SDH_DIV_RST;
            n.ists      = 32'h0000_0000;
            n.sten      = 32'h0000_0000;
            n.sgen      = 32'h0000_0000;
            n.div_cnt   = 8'h00;
            n.sdclk     = 1'b0;
            n.stb_cnt   = 8'h00;
            n.cst       = C_IDLE; // R15
            n.xst       = X_IDLE; // R15
            n.blk_left  = 16'h0000;
            n.byte_left = 12'h000;
        end

        // Address phase; read data captured here
        n.a_wr = 1'b0;
        if (HSEL && HREADY && HTRANS[1]) begin
            n.a_wr   = HWRITE;
            n.a_addr = HADDR[7:0];
            if (!HWRITE) begin
                unique case (HADDR[7:0])
                    `SDH_A_BLOCK_ATTRIBUTES_REG: n.rdata = s.block_attributes_reg;
                    `SDH_A_XMODE:   n.rdata = {27'h0, s.xmode};
                    `SDH_A_PRESENT: n.rdata = present;
                    `SDH_A_PROTO:   n.rdata = {28'h0, s.dat3_card_detect_ctrl, 3'h0};
                    `SDH_A_SYSCTL:  n.rdata = {16'h0, s.div, 4'h0,
                                               s.clken, 3'h0};
                    `SDH_A_ISTAT:   n.rdata = s.ists;
                    `SDH_A_ISTEN:   n.rdata = s.sten;
                    `SDH_A_ISGEN:   n.rdata = s.sgen;
                    default:        n.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s         <= '0;
            s.div     <= `SDH_DIV_RST;
            s.cmd_s1  <= 1'b1;
            s.cmd_s2  <= 1'b1;
            s.dat_s1  <= 4'hf;
            s.dat_s2  <= 4'hf;
            s.cst     <= C_IDLE;
            s.xst     <= X_IDLE;
        end else if (CE) begin
            s <= n;
        end
    end

    assign HRDATA      = s.rdata;
    assign HREADYOUT   = 1'b1;
    assign HRESP       = 1'b0;
    assign CARD_O.clk    = s.sdclk;
    assign CARD_O.cmd_o  = s.cst != C_SEND;
    assign CARD_O.cmd_oe = s.clken && s.cst == C_SEND; // R18
    assign IRQ = |(s.ists & s.sgen);

    property p_odd_stall;
        @(posedge CLK_SYS) disable iff (RST || !CE)
        blk_end && last && odd_stall && !reset_all_bit
        |=> s.xst == X_STALL && !$rose(s.ists[`SDH_IS_TC]);
    endproperty
    a_odd_stall: assert property (p_odd_stall) // R03
        else $error("odd block read did not stall");

    property p_one_stops;
        @(posedge CLK_SYS) disable iff (RST || !CE)
        blk_end && s.blk_left == 16'h0001 |=> s.xst != X_RUN;
    endproperty
    a_one_stops: assert property (p_one_stops) // R06
        else $error("count of one did not stop transfer");

    property p_false_err;
        @(posedge CLK_SYS) disable iff (RST || !CE)
        s.cst == C_WAIT && tick && !s.cmd_s2 && s.xst == X_RUN
        && FIFO_STALL && s.sten[`SDH_IS_CCE] && s.sten[`SDH_IS_CIE]
        && !reset_all_bit
        |=> s.ists[`SDH_IS_CCE] && s.ists[`SDH_IS_CIE] && s.cst == C_IDLE;
    endproperty
    a_false_err: assert property (p_false_err) // R08
        else $error("paused response start did not flag errors");

    property p_card_interrupt_flag_edge;
        @(posedge CLK_SYS) disable iff (RST || !CE)
        $rose(s.ists[`SDH_IS_CARD_INTERRUPT_FLAG])
        |-> $past(card_interrupt_flag_rise) && $past(s.sten[`SDH_IS_CARD_INTERRUPT_FLAG]);
    endproperty
    a_card_interrupt_flag_edge: assert property (p_card_interrupt_flag_edge) // R10
        else $error("card interrupt set without line edge");

    property p_card_interrupt_flag_clear;
        @(posedge CLK_SYS) disable iff (RST || !CE)
        wr && s.a_addr == `SDH_A_ISTAT && HWDATA[`SDH_IS_CARD_INTERRUPT_FLAG]
        && !card_interrupt_flag_rise |=> !s.ists[`SDH_IS_CARD_INTERRUPT_FLAG];
    endproperty
    a_card_interrupt_flag_clear: assert property (p_card_interrupt_flag_clear) // R11
        else $error("card interrupt flag not cleared");

    property p_dat3_card_detect_ctrl_low;
        @(posedge CLK_SYS) disable iff (RST || !CE)
        !s.dat3_card_detect_ctrl ##1 !s.dat3_card_detect_ctrl |-> !s.inv_prev;
    endproperty
    a_dat3_card_detect_ctrl_low: assert property (p_dat3_card_detect_ctrl_low) // R12
        else $error("inverted line not held low");

    property p_soft_rst;
        @(posedge CLK_SYS) disable iff (RST || !CE)
        reset_all_bit |=> s.cst == C_IDLE && s.xst == X_IDLE && !s.clken
        ##1 s.stb_cnt == 8'h01;
    endproperty
    a_soft_rst: assert property (p_soft_rst) // R15
        else $error("software reset left work in progress");

    property p_clk_off;
        @(posedge CLK_SYS) disable iff (RST || !CE)
        !s.clken |-> !CARD_O.clk && !CARD_O.cmd_oe
        ##1 (s.clken || $stable(CARD_O.clk));
    endproperty
    a_clk_off: assert property (p_clk_off) // R18
        else $error("card pins moved with clock disabled");
endmodule : sdh_ctrl

// ---- rtl/sdh_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// of the card host block; definitions only, included by the controller and the bench.
`ifndef SDH_REGS_SVH
`define SDH_REGS_SVH

`define SDH_A_BLOCK_ATTRIBUTES_REG  8'h00
`define SDH_A_XMODE    8'h04
`define SDH_A_PRESENT  8'h08
`define SDH_A_PROTO    8'h0c
`define SDH_A_SYSCTL   8'h10
`define SDH_A_ISTAT    8'h14
`define SDH_A_ISTEN    8'h18
`define SDH_A_ISGEN    8'h1c

`define SDH_BA_BSZ     0
`define SDH_BA_CNT     16
`define SDH_XM_BLOCK_COUNT_ENABLE    0
`define SDH_XM_DMA     1
`define SDH_XM_RD      2
`define SDH_XM_XSTART  3
`define SDH_XM_CSTART  4
`define SDH_PS_DLA     2
`define SDH_PS_STB     3
`define SDH_PS_DATA_LINE_LEVEL_BITS    24
`define SDH_PC_DAT3_CARD_DETECT_CTRL    3
`define SDH_SC_CLKEN   3
`define SDH_SC_DIV     8
`define SDH_SC_RESET_ALL_BIT    24
`define SDH_IS_CC      0
`define SDH_IS_TC      1
`define SDH_IS_CARD_INTERRUPT_FLAG    8
`define SDH_IS_CCE     16
`define SDH_IS_CIE     19

`define SDH_DIV_RST    8'h01
`define SDH_IS_MASK    32'h0009_0103

`define SDH_CLK_NS     40
`define SDH_STB_NS     2000
`define SDH_STB_CYC    ((`SDH_STB_NS + `SDH_CLK_NS - 1) / `SDH_CLK_NS)

`endif

// ---- rtl/sdh_pkg.sv ----
// Types of the card host block: state encodings, pin bundle, state.
// Widths here must match the field layout in sdh_regs.svh.
package sdh_pkg;
    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_SEND = 2'b01,
        C_WAIT = 2'b11
    } sdh_cst_t;

    typedef enum logic [1:0] {
        X_IDLE  = 2'b00,
        X_RUN   = 2'b01,
        X_STALL = 2'b11
    } sdh_xst_t;

    typedef struct packed {
        logic clk;
        logic cmd_o;
        logic cmd_oe;
    } sdh_card_o_t;

    typedef struct packed {
        logic [31:0] block_attributes_reg;
        logic [4:0]  xmode;
        logic        dat3_card_detect_ctrl;
        logic        clken;
        logic [7:0]  div;
        logic [31:0] ists;
        logic [31:0] sten;
        logic [31:0] sgen;
        logic        a_wr;
        logic [7:0]  a_addr;
        logic [31:0] rdata;
        logic        cmd_s1;
        logic        cmd_s2;
        logic [3:0]  dat_s1;
        logic [3:0]  dat_s2;
        logic [7:0]  div_cnt;
        logic        sdclk;
        logic [7:0]  stb_cnt;
        sdh_cst_t    cst;
        sdh_xst_t    xst;
        logic [15:0] blk_left;
        logic [11:0] byte_left;
        logic        inv_prev;
    } sdh_state_t;
endpackage : sdh_pkg

// ---- verif/sdh_card_model.sv ----
// Behavioural card on the far side of the link: answers commands on
// the host's clock. Assumes pull-ups on the command and data lines.
`timescale 1ns/100ps

module sdh_card_model #(
    parameter int RESP_DLY = 3
) (
    input  wire logic       card_clk,
    input  wire logic       cmd_oe,
    input  wire logic       int_req,
    input  wire logic       busy,
    output logic            cmd_line,
    output logic [3:0]      dat
);
    int rises_left;
    int low_left;

    initial begin
        rises_left = 0;
        low_left   = 0;
        cmd_line   = 1'b1;
    end

    // The card never starts anything by itself
    always @(posedge cmd_oe) begin
        rises_left = RESP_DLY;
    end

    // Response only moves on host clock rises
    always @(posedge card_clk) begin
        if (low_left > 0) begin
            low_left = low_left - 1;
            cmd_line = (low_left > 0) ? 1'b0 : 1'b1;
        end else if (rises_left > 0) begin
            rises_left = rises_left - 1;
            if (rises_left == 0) begin
                low_left = 2;
                cmd_line = 1'b0;
            end
        end
    end

    // Released lines float up through the pull-ups
    assign dat = {2'b11, ~int_req, ~busy};
endmodule : sdh_card_model

// ---- verif/sdh_host_dma_and_card_control_tb.sv ----
// Self-checking bench of the card host: bus master tasks, card model,
// one task per scenario. Assumes sdh_ctrl and sdh_card_model.
`timescale 1ns/100ps
`include "sdh_regs.svh"

module sdh_host_dma_and_card_control_tb;
    import sdh_pkg::*;
    logic        clk, rst, fifo_stall, int_req, busy, cmd_card;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic        hwrite, hready, hresp, cmd_i, irq;
    logic [3:0]  dat_i;
    sdh_card_o_t card_o;
    int          fail_count;
    int          cmp_count;

    // Wire level seen by the host; the card model sees only cmd_oe
    assign cmd_i = card_o.cmd_oe ? card_o.cmd_o : cmd_card;

    sdh_ctrl #(.STB_CYCLES(4)) sdh_ctrl_inst (
        .CLK_SYS(clk), .RST(rst), .CE(1'b1), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .CMD_I(cmd_i), .DAT_I(dat_i),
        .FIFO_STALL(fifo_stall), .CARD_O(card_o), .IRQ(irq));

    sdh_card_model sdh_card_model_inst (
        .card_clk(card_o.clk), .cmd_oe(card_o.cmd_oe), .int_req(int_req),
        .busy(busy), .cmd_line(cmd_card), .dat(dat_i));

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wait_rdy;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask : wait_rdy

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clk);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rg(input logic [7:0] a);
        bus(a, 1'b0, 32'h0);
    endtask : rg

    task automatic poll(input string what, input logic [7:0] a,
                        input int b, input logic v);
        for (int i = 0; i < 100; i++) begin
            rg(a);
            if (rd[b] === v) break;
        end
        chk(what, {31'h0, v}, {31'h0, rd[b]});
    endtask : poll

    task automatic t_off;
        int n;
        n = 0;
        chk("irq after reset", 32'h0, {31'h0, irq});
        chk("okay response", 32'h0, {31'h0, hresp});
        wr(`SDH_A_XMODE, 32'h10);
        repeat (20) begin
            @(posedge clk);
            if (card_o.clk !== 1'b0 || card_o.cmd_oe !== 1'b0) n++;
        end
        chk("quiet link", 32'h0, n);
        rg(8'h40);
        chk("unmapped", 32'h0, rd);
        rg(`SDH_A_ISTAT);
        chk("status after reset", 32'h0, rd);
    endtask : t_off

    task automatic t_clk;
        time t0;
        wr(`SDH_A_ISTEN, `SDH_IS_MASK);
        wr(`SDH_A_SYSCTL, 32'h0000_0300);
        poll("clock stable", `SDH_A_PRESENT, `SDH_PS_STB, 1'b1);
        wr(`SDH_A_SYSCTL, 32'h0000_0308);
        @(posedge card_o.clk);
        t0 = $time;
        @(posedge card_o.clk);
        chk("card clock ns", 32'd320, 32'($time - t0));
    endtask : t_clk

    task automatic t_cmd;
        wr(`SDH_A_XMODE, 32'h10);
        poll("cmd done", `SDH_A_ISTAT, `SDH_IS_CC, 1'b1);
        wr(`SDH_A_ISTAT, 32'h1);
        rg(`SDH_A_ISTAT);
        chk("cc cleared", 32'h0, rd);
    endtask : t_cmd

    task automatic t_xfer;
        wr(`SDH_A_BLOCK_ATTRIBUTES_REG, 32'h0001_0002);
        wr(`SDH_A_XMODE, 32'h08);
        poll("tc count one", `SDH_A_ISTAT, `SDH_IS_TC, 1'b1);
        wr(`SDH_A_ISTAT, 32'h2);
        wr(`SDH_A_BLOCK_ATTRIBUTES_REG, 32'h0001_0003);
        wr(`SDH_A_XMODE, 32'h0e);
        repeat (100) @(posedge clk);
        rg(`SDH_A_ISTAT);
        chk("no tc odd size", 32'h0, rd & 32'h2);
        rg(`SDH_A_PRESENT);
        chk("busy stuck", 32'h1, {31'h0, rd[`SDH_PS_DLA]});
        wr(`SDH_A_SYSCTL, 32'h0000_0300);
        wr(`SDH_A_SYSCTL, 32'h0100_0300);
        rg(`SDH_A_PRESENT);
        chk("busy abandoned", 32'h0, {31'h0, rd[`SDH_PS_DLA]});
        rg(`SDH_A_SYSCTL);
        chk("control reset", 32'h0000_0100, rd);
    endtask : t_xfer

    task automatic t_err;
        wr(`SDH_A_BLOCK_ATTRIBUTES_REG, 32'h0002_0002);
        fifo_stall <= 1'b1;
        wr(`SDH_A_XMODE, 32'h09);
        // Keep block counting on, or the running transfer never ends
        wr(`SDH_A_XMODE, 32'h11);
        poll("index err", `SDH_A_ISTAT, `SDH_IS_CIE, 1'b1);
        chk("false errors", 32'h0009_0000, rd & `SDH_IS_MASK);
        fifo_stall <= 1'b0;
        poll("data intact", `SDH_A_ISTAT, `SDH_IS_TC, 1'b1);
        wr(`SDH_A_ISTAT, 32'hffff_ffff);
        t_cmd();
    endtask : t_err

    task automatic t_card_interrupt_flag;
        wr(`SDH_A_ISTEN, 32'h0);
        wr(`SDH_A_ISGEN, 32'h0);
        int_req <= 1'b1;
        wr(`SDH_A_PROTO, 32'h8);
        wr(`SDH_A_ISTEN, `SDH_IS_MASK);
        wr(`SDH_A_ISGEN, 32'h100);
        rg(`SDH_A_ISTAT);
        chk("level missed", 32'h0, rd & 32'h100);
        chk("irq quiet", 32'h0, {31'h0, irq});
        wr(`SDH_A_PROTO, 32'h0);
        wr(`SDH_A_PROTO, 32'h8);
        rg(`SDH_A_ISTAT);
        chk("card_interrupt_flag re-armed", 32'h100, rd & 32'h100);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`SDH_A_ISTEN, 32'h0009_0003);
        wr(`SDH_A_ISGEN, 32'h0);
        // Mask lands on the edge just seen; look one edge later
        @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        int_req <= 1'b0;
        wr(`SDH_A_ISTAT, 32'h100);
        rg(`SDH_A_ISTAT);
        chk("card_interrupt_flag cleared", 32'h0, rd);
        wr(`SDH_A_PROTO, 32'h0);
        wr(`SDH_A_PROTO, 32'h8);
        wr(`SDH_A_ISTEN, `SDH_IS_MASK);
        wr(`SDH_A_ISGEN, 32'h100);
        int_req <= 1'b1;
        repeat (8) @(posedge clk);
        chk("new card irq", 32'h1, {31'h0, irq});
        int_req <= 1'b0;
        wr(`SDH_A_ISTAT, 32'h100);
        @(posedge clk);
        chk("irq dropped", 32'h0, {31'h0, irq});
    endtask : t_card_interrupt_flag

    task automatic t_busy;
        busy <= 1'b1;
        repeat (4) @(posedge clk);
        rg(`SDH_A_PRESENT);
        chk("line0 busy", 32'h0, {31'h0, rd[`SDH_PS_DATA_LINE_LEVEL_BITS]});
        busy <= 1'b0;
        repeat (4) @(posedge clk);
        rg(`SDH_A_PRESENT);
        chk("line0 free", 32'h1, {31'h0, rd[`SDH_PS_DATA_LINE_LEVEL_BITS]});
    endtask : t_busy

    task automatic t_long;
        wr(`SDH_A_BLOCK_ATTRIBUTES_REG, 32'h0001_0008);
        wr(`SDH_A_XMODE, 32'h0f);
        poll("padded read done", `SDH_A_ISTAT, `SDH_IS_TC, 1'b1);
        wr(`SDH_A_ISTAT, 32'h2);
        wr(`SDH_A_BLOCK_ATTRIBUTES_REG, 32'hffff_0004);
        wr(`SDH_A_XMODE, 32'h09);
        repeat (64) @(posedge clk);
        rg(`SDH_A_ISTAT);
        chk("long run no tc", 32'h0, rd & 32'h2);
        rg(`SDH_A_PRESENT);
        chk("long run active", 32'h1, {31'h0, rd[`SDH_PS_DLA]});
        wr(`SDH_A_SYSCTL, 32'h0000_0300);
        wr(`SDH_A_SYSCTL, 32'h0100_0300);
        rg(`SDH_A_PRESENT);
        chk("long run abandoned", 32'h0, {31'h0, rd[`SDH_PS_DLA]});
    endtask : t_long

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        rst        = 1'b1;
        haddr      = 32'h0;
        hwdata     = 32'h0;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        fifo_stall = 1'b0;
        int_req    = 1'b0;
        busy       = 1'b0;
        fail_count = 0;
        cmp_count  = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_off();
        t_clk();
        t_cmd();
        t_xfer();
        t_clk();
        t_err();
        t_card_interrupt_flag();
        t_busy();
        t_long();
        tally_and_finish();
    end

    // Whole run takes several hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule : sdh_host_dma_and_card_control_tb
